// ==== design/vcrc_pkg.sv ====
// constants for the channel resource configuration registers
// assumes a 100 MHz core clock and 32-bit register words on an AXI4-Lite slave
package vcrc_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam int          ADDR_W                   = 12;
  localparam logic [11:0] VC0_RESOURCE_CONTROL_OFF = 12'h15c;
  localparam logic [11:0] VC0_RESOURCE_STATUS_OFF  = 12'h160;
  localparam logic [11:0] VC1_RESOURCE_CAP_OFF     = 12'h164;

  // ------------------------------------------------------------
  // control word fields
  // ------------------------------------------------------------
  localparam int          MAP_LSB        = 0;
  localparam int          MAP_MSB        = 7;
  localparam int          LOAD_BIT       = 16;
  localparam int          SCHEME_LSB     = 17;
  localparam int          SCHEME_MSB     = 19;
  localparam int          CHAN_ID_LSB    = 24;
  localparam int          CHAN_ID_MSB    = 26;
  localparam int          ENABLE_BIT     = 31;
  localparam logic [7:0]  MAP_RESET      = 8'hff;
  localparam logic [7:0]  MAP_FIXED_MASK = 8'h01;
  localparam logic [2:0]  CHAN_ID_VALUE  = 3'h0;
  localparam logic        ENABLE_RESET   = 1'b1;

  // ------------------------------------------------------------
  // arbitration scheme codes accepted for the default channel
  // ------------------------------------------------------------
  localparam logic [2:0]  SCHEME_DEFAULT = 3'h0;
  localparam logic [2:0]  SCHEME_WRR     = 3'h3;

  // ------------------------------------------------------------
  // status word fields
  // ------------------------------------------------------------
  localparam int          TABLE_STATUS_BIT = 16;
  localparam int          NEG_PENDING_BIT  = 17;

  // ------------------------------------------------------------
  // second channel capability word
  // ------------------------------------------------------------
  localparam int          CAP_ARB_LSB      = 0;
  localparam int          CAP_ARB_MSB      = 7;
  localparam int          CAP_SLOTS_LSB    = 16;
  localparam int          CAP_SLOTS_MSB    = 22;
  localparam int          CAP_OFFSET_LSB   = 24;
  localparam int          CAP_OFFSET_MSB   = 31;
  localparam logic [7:0]  CAP_ARB_PRESENT  = 8'h13;
  localparam logic [6:0]  CAP_SLOTS_PRESENT = 7'h3f;
  localparam logic [7:0]  CAP_OFFSET_PRESENT = 8'h06;

  // ------------------------------------------------------------
  // timing and bus answers
  // ------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          LOAD_TIME_NS    = 80;
  localparam int          LOAD_CYCLES     = (LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage : vcrc_pkg

// ==== design/vcrc_axil_slave.sv ====
// AXI4-Lite slave front end: takes one write and one read at a time
// assumes the register file answers reads and write decode combinationally
module vcrc_axil_slave #(
  parameter int ADDR_W = vcrc_pkg::ADDR_W
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   wr_fire,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [31:0]            wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_ok,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_ok
);

  logic aw_held_reg;
  logic w_held_reg;

  // ------------------------------------------------------------
  // write side
  // ------------------------------------------------------------
  // write happens once address and data are both held
  assign wr_fire = aw_held_reg & w_held_reg & ~bvalid;

  // address channel capture, ready drops until the response is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready     <= 1'b1;
      aw_held_reg <= 1'b0;
      wr_addr     <= '0;
    end
    else if (awvalid && awready)
    begin
      awready     <= 1'b0;
      aw_held_reg <= 1'b1;
      wr_addr     <= awaddr;
    end
    else
    begin
      if (wr_fire)
        aw_held_reg <= 1'b0;
      if (bvalid && bready)
        awready <= 1'b1;
    end
  end

  // data channel capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready     <= 1'b1;
      w_held_reg <= 1'b0;
      wr_data    <= '0;
      wr_strb    <= '0;
    end
    else if (wvalid && wready)
    begin
      wready     <= 1'b0;
      w_held_reg <= 1'b1;
      wr_data    <= wdata;
      wr_strb    <= wstrb;
    end
    else
    begin
      if (wr_fire)
        w_held_reg <= 1'b0;
      if (bvalid && bready)
        wready <= 1'b1;
    end
  end

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= vcrc_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? vcrc_pkg::RESP_OKAY : vcrc_pkg::RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // ------------------------------------------------------------
  // read side
  // ------------------------------------------------------------
  // data is sampled at the address handshake and held until taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= vcrc_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_data;
      rresp   <= rd_ok ? vcrc_pkg::RESP_OKAY : vcrc_pkg::RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule : vcrc_axil_slave

// ==== design/vcrc_table_loader.sv ====
// sequencer that applies the stored port arbitration table to the arbiter
// assumes a one-cycle start pulse; further starts while busy are ignored
module vcrc_table_loader #(
  parameter int LOAD_CYCLES = vcrc_pkg::LOAD_CYCLES
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic start,
  output logic      apply,
  output logic      busy,
  output logic      done
);

  typedef enum logic [0:0] {VCRC_LD_IDLE, VCRC_LD_RUN} vcrc_ld_state_t;

  vcrc_ld_state_t    state_reg;
  logic [15:0]       count_reg;
  localparam logic [15:0] LAST_COUNT = 16'(LOAD_CYCLES - 1);

  // ------------------------------------------------------------
  // load sequence
  // ------------------------------------------------------------
  // apply pulses at start, done pulses after the load time has run
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= VCRC_LD_IDLE;
      count_reg <= '0;
      apply     <= 1'b0;
      busy      <= 1'b0;
      done      <= 1'b0;
    end
    else
    begin
      apply <= 1'b0;
      done  <= 1'b0;
      case (state_reg)
        VCRC_LD_IDLE:
        begin
          if (start)
          begin
            state_reg <= VCRC_LD_RUN;
            count_reg <= '0;
            apply     <= 1'b1;
            busy      <= 1'b1;
          end
        end
        VCRC_LD_RUN:
        begin
          if (count_reg == LAST_COUNT)
          begin
            state_reg <= VCRC_LD_IDLE;
            busy      <= 1'b0;
            done      <= 1'b1;
          end
          else
            count_reg <= count_reg + 16'h0001;
        end
        default:
          state_reg <= VCRC_LD_IDLE;
      endcase
    end
  end

endmodule : vcrc_table_loader

// ==== design/vcrc_regs.sv ====
// default channel control/status and second channel capability registers
// assumes the table store raises a pulse per entry write and the link layer
// reports channel negotiation as a level; all inputs synchronous to aclk
// Operation
// R01: each bit of the 8-bit class map maps that traffic class onto the default channel.
// R02: map bit 0 is read-only one and the whole map resets to all ones.
// R03: writing one to the table load bit applies the stored port table; the bit reads zero.
// R04: the arbitration scheme select accepts only codes 000b and 011b.
// R05: any other written scheme code is treated as the default code 000b.
// R06: the channel identifier is read-only and reads 000b.
// R07: the enable bit 31 disables (0) or enables (1) the channel and resets to one.
// R08: the read-only table status bit sets when software writes any table entry.
// R09: the table status bit clears when the hardware finishes loading after a load request.
// R10: the negotiation pending bit follows the negotiation in progress and resets to zero.
// R11: second channel arbitration capability reads 13h when present, 00h when absent.
// R12: second channel time-slot field reads 3Fh when present, 00h when absent.
// R13: second channel table offset reads 06h (16-byte units) when present, 00h when absent.
// R14: snoop-rejection and packet-switching-only bits of the capability word read zero.
// R15: reserved bits read zero and writes to them do nothing.
module vcrc_regs #(
  parameter int ADDR_W      = vcrc_pkg::ADDR_W,
  parameter int LOAD_CYCLES = vcrc_pkg::LOAD_CYCLES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axil_awaddr,
  input  wire logic              s_axil_awvalid,
  output logic                   s_axil_awready,
  input  wire logic [31:0]       s_axil_wdata,
  input  wire logic [3:0]        s_axil_wstrb,
  input  wire logic              s_axil_wvalid,
  output logic                   s_axil_wready,
  output logic [1:0]             s_axil_bresp,
  output logic                   s_axil_bvalid,
  input  wire logic              s_axil_bready,
  input  wire logic [ADDR_W-1:0] s_axil_araddr,
  input  wire logic              s_axil_arvalid,
  output logic                   s_axil_arready,
  output logic [31:0]            s_axil_rdata,
  output logic [1:0]             s_axil_rresp,
  output logic                   s_axil_rvalid,
  input  wire logic              s_axil_rready,
  input  wire logic              second_channel_present,
  input  wire logic              table_entry_written,
  input  wire logic              negotiation_busy,
  output logic [7:0]             class_to_channel_map,
  output logic [2:0]             port_arb_scheme,
  output logic                   channel_enable,
  output logic                   table_apply,
  output logic                   table_load_busy
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // word address match, low two bits ignored
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [11:0] off);
    reg_hit = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction : reg_hit

  // only the two supported scheme codes pass, anything else becomes default
  function automatic logic [2:0] scheme_filter(input logic [2:0] code);
    if (code == vcrc_pkg::SCHEME_WRR)
      scheme_filter = vcrc_pkg::SCHEME_WRR;
    else
      scheme_filter = vcrc_pkg::SCHEME_DEFAULT;
  endfunction : scheme_filter

  logic              wr_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_ok;
  logic [31:0]       rd_data;
  logic              rd_ok;
  logic              ctrl_wr;
  logic              load_start;
  logic              load_done;
  logic              table_status_reg;
  logic              neg_pending_reg;
  logic              present_reg;
  logic [31:0]       ctrl_word;
  logic [31:0]       status_word;
  logic [31:0]       cap_word;

  // ------------------------------------------------------------
  // bus front end
  // ------------------------------------------------------------
  vcrc_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axil_awaddr),
    .awvalid (s_axil_awvalid),
    .awready (s_axil_awready),
    .wdata   (s_axil_wdata),
    .wstrb   (s_axil_wstrb),
    .wvalid  (s_axil_wvalid),
    .wready  (s_axil_wready),
    .bresp   (s_axil_bresp),
    .bvalid  (s_axil_bvalid),
    .bready  (s_axil_bready),
    .araddr  (s_axil_araddr),
    .arvalid (s_axil_arvalid),
    .arready (s_axil_arready),
    .rdata   (s_axil_rdata),
    .rresp   (s_axil_rresp),
    .rvalid  (s_axil_rvalid),
    .rready  (s_axil_rready),
    .wr_fire (wr_fire),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  // read-only words accept writes silently; unmapped words answer error
  assign ctrl_wr    = wr_fire & reg_hit(wr_addr, vcrc_pkg::VC0_RESOURCE_CONTROL_OFF);
  assign wr_ok      = reg_hit(wr_addr, vcrc_pkg::VC0_RESOURCE_CONTROL_OFF)
                    | reg_hit(wr_addr, vcrc_pkg::VC0_RESOURCE_STATUS_OFF)
                    | reg_hit(wr_addr, vcrc_pkg::VC1_RESOURCE_CAP_OFF);
  assign load_start = ctrl_wr & wr_strb[vcrc_pkg::LOAD_BIT/8] & wr_data[vcrc_pkg::LOAD_BIT]; // R03

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  // class map, byte 0; bit 0 forced to one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      class_to_channel_map <= vcrc_pkg::MAP_RESET; // R02
    else if (ctrl_wr && wr_strb[0])
      class_to_channel_map <= wr_data[vcrc_pkg::MAP_MSB:vcrc_pkg::MAP_LSB] | vcrc_pkg::MAP_FIXED_MASK; // R01 R02
  end

  // scheme select, byte 2; unsupported codes stored as default
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      port_arb_scheme <= vcrc_pkg::SCHEME_DEFAULT;
    else if (ctrl_wr && wr_strb[vcrc_pkg::SCHEME_LSB/8])
      port_arb_scheme <= scheme_filter(wr_data[vcrc_pkg::SCHEME_MSB:vcrc_pkg::SCHEME_LSB]); // R04 R05
  end

  // channel enable, byte 3
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      channel_enable <= vcrc_pkg::ENABLE_RESET; // R07
    else if (ctrl_wr && wr_strb[vcrc_pkg::ENABLE_BIT/8])
      channel_enable <= wr_data[vcrc_pkg::ENABLE_BIT]; // R07
  end

  // ------------------------------------------------------------
  // table load sequencing and status
  // ------------------------------------------------------------
  vcrc_table_loader #(
    .LOAD_CYCLES (LOAD_CYCLES)
  ) u_loader (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (load_start),
    .apply   (table_apply),
    .busy    (table_load_busy),
    .done    (load_done)
  );

  // entry write sets, finished load clears; a set in the same cycle wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      table_status_reg <= 1'b0;
    else if (table_entry_written)
      table_status_reg <= 1'b1; // R08
    else if (load_done)
      table_status_reg <= 1'b0; // R09
  end

  // negotiation pending follows the link layer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      neg_pending_reg <= 1'b0;
    else
      neg_pending_reg <= negotiation_busy; // R10
  end

  // second channel presence, taken every cycle after reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      present_reg <= 1'b0;
    else
      present_reg <= second_channel_present;
  end

  // ------------------------------------------------------------
  // read words
  // ------------------------------------------------------------
  // load bit, identifier and reserved bits read zero
  always_comb
  begin
    ctrl_word = '0; // R15
    ctrl_word[vcrc_pkg::MAP_MSB:vcrc_pkg::MAP_LSB] = class_to_channel_map; // R01
    ctrl_word[vcrc_pkg::SCHEME_MSB:vcrc_pkg::SCHEME_LSB] = port_arb_scheme;
    ctrl_word[vcrc_pkg::CHAN_ID_MSB:vcrc_pkg::CHAN_ID_LSB] = vcrc_pkg::CHAN_ID_VALUE; // R06
    ctrl_word[vcrc_pkg::ENABLE_BIT] = channel_enable;
  end

  // status word
  always_comb
  begin
    status_word = '0; // R15
    status_word[vcrc_pkg::TABLE_STATUS_BIT] = table_status_reg; // R08
    status_word[vcrc_pkg::NEG_PENDING_BIT] = neg_pending_reg; // R10
  end

  // capability word, all zero when the second channel is absent
  always_comb
  begin
    cap_word = '0; // R14 R15
    if (present_reg)
    begin
      cap_word[vcrc_pkg::CAP_ARB_MSB:vcrc_pkg::CAP_ARB_LSB] = vcrc_pkg::CAP_ARB_PRESENT; // R11
      cap_word[vcrc_pkg::CAP_SLOTS_MSB:vcrc_pkg::CAP_SLOTS_LSB] = vcrc_pkg::CAP_SLOTS_PRESENT; // R12
      cap_word[vcrc_pkg::CAP_OFFSET_MSB:vcrc_pkg::CAP_OFFSET_LSB] = vcrc_pkg::CAP_OFFSET_PRESENT; // R13
    end
  end

  // read address decode
  always_comb
  begin
    rd_data = '0;
    rd_ok   = 1'b1;
    if (reg_hit(s_axil_araddr, vcrc_pkg::VC0_RESOURCE_CONTROL_OFF))
      rd_data = ctrl_word;
    else if (reg_hit(s_axil_araddr, vcrc_pkg::VC0_RESOURCE_STATUS_OFF))
      rd_data = status_word;
    else if (reg_hit(s_axil_araddr, vcrc_pkg::VC1_RESOURCE_CAP_OFF))
      rd_data = cap_word;
    else
      rd_ok = 1'b0;
  end

endmodule : vcrc_regs

// ==== dv/vcrc_regs_chk.sv ====
// assertions for the channel resource registers
// assumes it is bound to vcrc_regs and sees only that module's ports
module vcrc_regs_chk #(
  parameter int LOAD_CYCLES = 8
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axil_awvalid,
  input wire logic        s_axil_awready,
  input wire logic        s_axil_wvalid,
  input wire logic        s_axil_wready,
  input wire logic [1:0]  s_axil_bresp,
  input wire logic        s_axil_bvalid,
  input wire logic        s_axil_bready,
  input wire logic        s_axil_arvalid,
  input wire logic        s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic        s_axil_rvalid,
  input wire logic        s_axil_rready,
  input wire logic [7:0]  class_to_channel_map,
  input wire logic [2:0]  port_arb_scheme,
  input wire logic        channel_enable,
  input wire logic        table_apply,
  input wire logic        table_load_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  logic [7:0] busy_cnt;

  // counts the cycles the loader has been busy
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !table_load_busy)
      busy_cnt <= 8'h00;
    else
      busy_cnt <= busy_cnt + 8'h01;
  end

  sequence wr_taken;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
  endsequence

  sequence rd_taken;
    s_axil_arvalid && s_axil_arready;
  endsequence

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  map_bit_fixed_a: assert property (class_to_channel_map[0] == 1'b1)
    else $error("class map bit 0 is clear");
  reset_values_a: assert property ($rose(aresetn) |-> class_to_channel_map == 8'hff && channel_enable)
    else $error("control outputs wrong after reset");
  scheme_legal_a: assert property (port_arb_scheme == 3'h0 || port_arb_scheme == 3'h3)
    else $error("unsupported scheme on output");
  apply_pulse_a: assert property (table_apply |-> $rose(table_load_busy) ##1 !table_apply)
    else $error("table apply is not a single pulse at busy start");
  busy_span_a: assert property ($fell(table_load_busy) |-> busy_cnt == 8'(LOAD_CYCLES))
    else $error("table load time wrong");
  write_answer_a: assert property (wr_taken |-> ##[1:2] s_axil_bvalid)
    else $error("write response missing");
  bresp_hold_a: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
    else $error("write response dropped early");
  read_answer_a: assert property (rd_taken |=> s_axil_rvalid)
    else $error("read data missing");
  rdata_hold_a: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
    else $error("read data dropped early");
  read_block_a: assert property (s_axil_rvalid |-> !s_axil_arready)
    else $error("read address taken while data pending");
endmodule : vcrc_regs_chk

bind vcrc_regs vcrc_regs_chk #(.LOAD_CYCLES(LOAD_CYCLES)) u_chk (
  .aclk, .aresetn, .s_axil_awvalid, .s_axil_awready, .s_axil_wvalid, .s_axil_wready,
  .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_arvalid, .s_axil_arready,
  .s_axil_rdata, .s_axil_rvalid, .s_axil_rready, .class_to_channel_map, .port_arb_scheme,
  .channel_enable, .table_apply, .table_load_busy
);

// ==== dv/vc_resource_config_regs_test.sv ====
// self-checking bench for the channel resource registers
// assumes vcrc_regs as the top, driven over AXI4-Lite with a 100 MHz clock
module vc_resource_config_regs_test;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int          LC   = 2;
  localparam logic [11:0] CTRL = vcrc_pkg::VC0_RESOURCE_CONTROL_OFF;
  localparam logic [11:0] STAT = vcrc_pkg::VC0_RESOURCE_STATUS_OFF;
  localparam logic [11:0] CAP  = vcrc_pkg::VC1_RESOURCE_CAP_OFF;
  localparam logic [1:0]  OK   = vcrc_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR  = vcrc_pkg::RESP_SLVERR;

  logic        aclk = 1'b0;
  logic        aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, present, entry_wr, neg_busy;
  logic        enable, apply, busy;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  map;
  logic [2:0]  scheme;
  int          n_errors = 0;
  int          tests_run = 0;
  int          apply_cnt = 0;

  vcrc_regs #(.LOAD_CYCLES(LC)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
    .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
    .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
    .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
    .second_channel_present(present), .table_entry_written(entry_wr), .negotiation_busy(neg_busy),
    .class_to_channel_map(map), .port_arb_scheme(scheme), .channel_enable(enable),
    .table_apply(apply), .table_load_busy(busy)
  );

  // ------------------------------------------------------------
  // clock, watchdog and pulse monitor
  // ------------------------------------------------------------
  always #5 aclk = ~aclk;

  initial
  begin
    #50000;
    n_errors++;
    wrap_up();
  end

  // counts table apply pulses
  always @(posedge aclk)
    if (apply === 1'b1) apply_cnt++;

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic guard(inout int t);
    t++;
    if (t > 200)
    begin
      n_errors++;
      wrap_up();
    end
  endtask : guard

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    int   t;
    logic aw_ok;
    logic w_ok;
    t = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (awvalid && awready)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      guard(t);
    end
    // response ready goes up only once both halves are taken
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      guard(t);
    end
    while (bvalid !== 1'b1);
    check(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    int t;
    t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      guard(t);
    end
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      guard(t);
    end
    while (rvalid !== 1'b1);
    check(rdata, exp);
    check(32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask : axi_read

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset

  task automatic wrap_up;
    if (n_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [7:0] m;
    logic [2:0] sc;
    {awvalid, wvalid, bready, arvalid, rready, present, entry_wr, neg_busy} <= 8'h00;
    {awaddr, araddr, wdata, wstrb} <= 60'h0;
    do_reset();
    check({24'h0, map}, 32'h0000_00ff);
    check(32'(enable), 32'h1);
    axi_read(CTRL, 32'h8000_00ff, OK);
    axi_read(STAT, 32'h0, OK);
    axi_read(CAP, 32'h0, OK);
    present <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_read(CAP, 32'h063f_0013, OK);
    // every scheme code, with a changing map and enable
    for (int c = 0; c < 8; c++)
    begin
      m = 8'(c * 37);
      sc = (c == 0 || c == 3) ? 3'(c) : 3'h0;
      axi_write(CTRL, {c[0], 11'h0, 3'(c), 1'b0, 8'h0, m}, 4'hf, OK);
      axi_read(CTRL, {c[0], 11'h0, sc, 1'b0, 8'h0, m | 8'h01}, OK);
      check(32'(scheme), 32'(sc));
      check(32'(enable), 32'(c[0]));
      check({24'h0, map}, {24'h0, m | 8'h01});
    end
    // reserved and identifier bits stay zero
    axi_write(CTRL, 32'h7ef0_ff00, 4'hf, OK);
    axi_read(CTRL, 32'h0000_0001, OK);
    axi_write(CTRL, 32'h8000_00fe, 4'h8, OK);
    axi_read(CTRL, 32'h8000_0001, OK);
    // table status set by an entry write, cleared by a load
    entry_wr <= 1'b1;
    @(posedge aclk);
    entry_wr <= 1'b0;
    repeat (2) @(posedge aclk);
    axi_read(STAT, 32'h0001_0000, OK);
    axi_write(CTRL, 32'h0001_0000, 4'h4, OK);
    check(32'(busy), 32'h1);
    repeat (LC + 3) @(posedge aclk);
    check(32'(busy), 32'h0);
    check(32'(apply_cnt), 32'h1);
    axi_read(STAT, 32'h0, OK);
    axi_read(CTRL, 32'h8000_0001, OK);
    // negotiation pending follows the link
    neg_busy <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_read(STAT, 32'h0002_0000, OK);
    neg_busy <= 1'b0;
    repeat (2) @(posedge aclk);
    axi_read(STAT, 32'h0, OK);
    // unmapped and read-only places
    axi_read(12'h168, 32'h0, ERR);
    axi_write(12'h100, 32'hffff_ffff, 4'hf, ERR);
    axi_write(STAT, 32'hffff_ffff, 4'hf, OK);
    axi_write(CAP, 32'hffff_ffff, 4'hf, OK);
    axi_read(STAT, 32'h0, OK);
    axi_read(CAP, 32'h063f_0013, OK);
    axi_read(CTRL, 32'h8000_0001, OK);
    // reset in mid-run
    do_reset();
    axi_read(CTRL, 32'h8000_00ff, OK);
    wrap_up();
  end
endmodule : vc_resource_config_regs_test
